/* spic_pkg.sv */
// package of constants and types for the serializer parallel input capture block
package spic_pkg;

  // register bus geometry
  localparam int AXI_ADDR_W = 4;
  localparam int AXI_DATA_W = 32;

  // register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_VSYNC_CNT = 4'h8;

  // control register fields and reset value
  localparam int CTRL_FILT_LSB = 0;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // status register fields
  localparam int STAT_CTL_LSB = 0;
  localparam int STAT_PD_BIT = 3;
  localparam int STAT_FILT_LSB = 4;

  // control filter mode codes
  localparam logic [1:0] FILT_OFF = 2'h0;
  localparam logic [1:0] FILT_ON = 2'h1;
  localparam logic [1:0] FILT_COMPAT_A = 2'h2;
  localparam logic [1:0] FILT_COMPAT_B = 2'h3;

  // least control pulse width passed by the filter, in pixel clocks
  localparam int FILT_MIN_PULSE = 3;
  localparam logic [1:0] FILT_LAST_CNT = 2'(FILT_MIN_PULSE - 1);

  // supported pixel clock range in MHz
  localparam int PIX_CLK_MIN_MHZ = 10;
  localparam int PIX_CLK_MAX_MHZ = 75;

  // colour byte positions in the pixel word
  localparam int RED_LSB = 0;
  localparam int GREEN_LSB = 8;
  localparam int BLUE_LSB = 16;

  // scrambler
  localparam int LFSR_W = 16;
  localparam logic [15:0] LFSR_SEED = 16'hace1;

  // line symbol: start bit, invert flag, 27 payload bits, stop bit
  localparam int PAY_W = 27;
  localparam int SYM_W = 30;
  localparam logic [29:0] SYM_IDLE = 30'h3fffffff;
  localparam logic signed [7:0] DISP_MID = 8'sh1c;

  // vsync event counter width
  localparam int VCNT_W = 16;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic vsync;
    logic hsync;
    logic de;
  } spic_ctl_t;

  typedef struct packed {
    spic_ctl_t ctl;
    logic [23:0] data;
  } spic_pix_t;

endpackage

/* spic_src.sv */
// pixel source model: pixel clock, pixel word and control lines
`timescale 1ns/1ps
`default_nettype none
module spic_src (
  input wire logic edge_sel,
  input wire logic [23:0] word,
  input wire spic_pkg::spic_ctl_t ctl,
  output logic pclk,
  output logic [23:0] pix,
  output var spic_pkg::spic_ctl_t ctl_o
);
  // free-running pixel clock, phase unrelated to the system clock
  initial begin
    pclk = 1'h0;
    pix = 24'h0;
    ctl_o = '0;
    #7;
    forever #40 pclk = ~pclk;
  end
  // launch on the edge opposite the capture edge, colour bytes in place
  always @(pclk) begin
    if (pclk != edge_sel) begin
      pix <= word;
      ctl_o <= ctl;
    end
  end
endmodule
`default_nettype wire

/* spic_top.sv */
// parallel pixel capture, control filter, scrambler and dc-balance encoder
//
// Summary of operation
// - take 24 data and 3 control bits
// - filter on passes pulses of three clocks
// - filter off passes every control transition
// - capture on the selected clock edge
// - scramble data before serializing
// - dc-balance the line symbols
// - pixel clock runs 10 to 75 MHz
// - select high rising edge, low falling
// - power-down resets control and stops output
`timescale 1ns/1ps
`default_nettype none

module spic_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pixel_clock_in,
  input wire logic strobe_edge_select,
  input wire logic power_down_n,
  input wire logic [23:0] pixel_data_in,
  input wire logic ctl_in_data_enable,
  input wire logic ctl_in_hsync,
  input wire logic ctl_in_vsync,
  output logic [29:0] tx_symbol,
  output logic tx_symbol_valid
);

  typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} spic_wr_t;
  typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_DATA = 2'b10} spic_rd_t;

  // word-aligned offset of a bus address
  function automatic logic [3:0] spic_word(input logic [3:0] a);
    spic_word = {a[3:2], 2'b00};
  endfunction

  // number of ones in the payload
  function automatic logic [4:0] spic_ones(input logic [26:0] v);
    logic [4:0] n;
    n = 5'h0;
    for (int i = 0; i < spic_pkg::PAY_W; i++) begin
      n = n + {4'h0, v[i]};
    end
    spic_ones = n;
  endfunction

  // gray code back to binary
  function automatic logic [15:0] spic_g2b(input logic [15:0] g);
    logic [15:0] b;
    b = 16'h0;
    b[15] = g[15];
    for (int i = 14; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    spic_g2b = b;
  endfunction

  // ---------------- system clock domain ----------------

  logic pd_meta_r;
  logic pd_n_r;
  logic sys_ok_r;
  logic [1:0] ctrl_filt_r;
  spic_wr_t wr_state_r;
  spic_rd_t rd_state_r;
  logic aw_got_r;
  logic w_got_r;
  logic [3:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [2:0] ctl_meta_r;
  logic [2:0] ctl_sync_r;
  logic [1:0] fmode_meta_r;
  logic [1:0] fmode_sync_r;
  logic [15:0] vg_meta_r;
  logic [15:0] vg_sync_r;
  logic [1:0] fmode_l_r;
  logic [2:0] ctl_tx_r;
  logic [15:0] vcnt_gray_r;

  // power-down pin through two flops, then the combined run level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pd_meta_r <= 1'b0;
      pd_n_r <= 1'b0;
      sys_ok_r <= 1'b0;
    end else begin
      pd_meta_r <= power_down_n;
      pd_n_r <= pd_meta_r;
      sys_ok_r <= pd_n_r;
    end
  end

  // write channel handshakes and the merged address and data
  logic aw_fire;
  logic w_fire;
  logic aw_now;
  logic w_now;
  logic [3:0] waddr_now;
  logic [31:0] wdata_now;
  logic [3:0] wstrb_now;
  assign s_axi_awready = (wr_state_r == WR_IDLE) && !aw_got_r;
  assign s_axi_wready = (wr_state_r == WR_IDLE) && !w_got_r;
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign aw_now = aw_got_r || aw_fire;
  assign w_now = w_got_r || w_fire;
  assign waddr_now = aw_fire ? s_axi_awaddr : awaddr_r;
  assign wdata_now = w_fire ? s_axi_wdata : wdata_r;
  assign wstrb_now = w_fire ? s_axi_wstrb : wstrb_r;
  assign s_axi_bvalid = (wr_state_r == WR_RESP);
  assign s_axi_bresp = bresp_r;

  // write state machine, address and data taken in either order
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_state_r <= WR_IDLE;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      bresp_r <= spic_pkg::RESP_OKAY;
    end else begin
      unique case (wr_state_r)
        WR_IDLE: begin
          if (aw_fire) begin
            awaddr_r <= s_axi_awaddr;
          end
          if (w_fire) begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
          end
          if (aw_now && w_now) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            wr_state_r <= WR_RESP;
            if (spic_word(waddr_now) == spic_pkg::REG_CTRL ||
                spic_word(waddr_now) == spic_pkg::REG_STATUS ||
                spic_word(waddr_now) == spic_pkg::REG_VSYNC_CNT) begin
              bresp_r <= spic_pkg::RESP_OKAY;
            end else begin
              bresp_r <= spic_pkg::RESP_SLVERR;
            end
          end else begin
            aw_got_r <= aw_now;
            w_got_r <= w_now;
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_r <= WR_IDLE;
          end
        end
      endcase
    end
  end

  // control register: filter mode, cleared by power-down
  always_ff @(posedge clk) begin
    if (!rst_n || !pd_n_r) begin
      ctrl_filt_r <= spic_pkg::CTRL_RESET;
    end else if (wr_state_r == WR_IDLE && aw_now && w_now && wstrb_now[0] &&
                 spic_word(waddr_now) == spic_pkg::REG_CTRL) begin
      ctrl_filt_r <= wdata_now[spic_pkg::CTRL_FILT_LSB +: 2];
    end
  end

  // link-side state brought over: levels by two flops, counter as gray
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl_meta_r <= 3'h0;
      ctl_sync_r <= 3'h0;
      fmode_meta_r <= 2'h0;
      fmode_sync_r <= 2'h0;
      vg_meta_r <= 16'h0;
      vg_sync_r <= 16'h0;
    end else begin
      ctl_meta_r <= ctl_tx_r;
      ctl_sync_r <= ctl_meta_r;
      fmode_meta_r <= fmode_l_r;
      fmode_sync_r <= fmode_meta_r;
      vg_meta_r <= vcnt_gray_r;
      vg_sync_r <= vg_meta_r;
    end
  end

  // read state machine with registered data
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (spic_word(s_axi_araddr))
      spic_pkg::REG_CTRL: rd_mux[spic_pkg::CTRL_FILT_LSB +: 2] = ctrl_filt_r;
      spic_pkg::REG_STATUS: begin
        rd_mux[spic_pkg::STAT_CTL_LSB +: 3] = ctl_sync_r;
        rd_mux[spic_pkg::STAT_PD_BIT] = !pd_n_r;
        rd_mux[spic_pkg::STAT_FILT_LSB +: 2] = fmode_sync_r;
      end
      spic_pkg::REG_VSYNC_CNT: rd_mux[15:0] = spic_g2b(vg_sync_r);
      default: rd_mux = 32'h0;
    endcase
  end

  assign s_axi_arready = (rd_state_r == RD_IDLE);
  assign s_axi_rvalid = (rd_state_r == RD_DATA);
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_state_r <= RD_IDLE;
      rdata_r <= 32'h0;
      rresp_r <= spic_pkg::RESP_OKAY;
    end else begin
      unique case (rd_state_r)
        RD_IDLE: begin
          if (s_axi_arvalid) begin
            rdata_r <= rd_mux;
            rd_state_r <= RD_DATA;
            if (spic_word(s_axi_araddr) == spic_pkg::REG_CTRL ||
                spic_word(s_axi_araddr) == spic_pkg::REG_STATUS ||
                spic_word(s_axi_araddr) == spic_pkg::REG_VSYNC_CNT) begin
              rresp_r <= spic_pkg::RESP_OKAY;
            end else begin
              rresp_r <= spic_pkg::RESP_SLVERR;
            end
          end
        end
        RD_DATA: begin
          if (s_axi_rready) begin
            rd_state_r <= RD_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------- pixel clock domain ----------------

  logic lrst_meta_r;
  logic lrst_n_r;
  logic esel_meta_r;
  logic esel_r;
  logic [1:0] fmode_meta_l_r;
  spic_pkg::spic_pix_t pins;
  spic_pkg::spic_pix_t cap_rise_r;
  spic_pkg::spic_pix_t cap_fall_r;
  spic_pkg::spic_pix_t cap_r;
  logic [23:0] data_d_r;
  logic [15:0] lfsr_r;
  logic signed [7:0] rd_r;
  logic [29:0] sym_r;
  logic sym_vld_r;
  logic vs_prev_r;
  logic [15:0] vcnt_r;

  assign pins = {ctl_in_vsync, ctl_in_hsync, ctl_in_data_enable, pixel_data_in};

  // reset, edge select and filter mode brought in through two flops
  always_ff @(posedge pixel_clock_in) begin
    lrst_meta_r <= sys_ok_r;
    lrst_n_r <= lrst_meta_r;
    esel_meta_r <= strobe_edge_select;
    esel_r <= esel_meta_r;
    fmode_meta_l_r <= ctrl_filt_r;
    fmode_l_r <= fmode_meta_l_r;
  end

  // capture on both edges; falling data is half a cycle old at the rise
  always_ff @(posedge pixel_clock_in) begin
    cap_rise_r <= pins;
  end
  always_ff @(negedge pixel_clock_in) begin
    cap_fall_r <= pins;
  end
  always_ff @(posedge pixel_clock_in) begin
    if (!lrst_n_r) begin
      cap_r <= '0;
    end else begin
      cap_r <= esel_r ? cap_rise_r : cap_fall_r;
    end
  end

  // control filter, one per control line; compat codes run unfiltered
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_filt
      logic [1:0] cnt_r;
      logic out_r;
      always_ff @(posedge pixel_clock_in) begin
        if (!lrst_n_r) begin
          cnt_r <= 2'h0;
          out_r <= 1'b0;
        end else if (fmode_l_r != spic_pkg::FILT_ON) begin
          cnt_r <= 2'h0;
          out_r <= cap_r.ctl[g];
        end else if (cap_r.ctl[g] == out_r) begin
          cnt_r <= 2'h0;
        end else if (cnt_r == spic_pkg::FILT_LAST_CNT) begin
          cnt_r <= 2'h0;
          out_r <= cap_r.ctl[g];
        end else begin
          cnt_r <= cnt_r + 2'h1;
        end
      end
      assign ctl_tx_r[g] = out_r;
    end
  endgenerate

  // data delayed to line up with the filtered control bits
  always_ff @(posedge pixel_clock_in) begin
    data_d_r <= cap_r.data;
  end

  // scramble, then choose polarity against the running disparity
  logic [26:0] payload;
  logic signed [7:0] disp;
  logic invert;
  assign payload = {ctl_tx_r, data_d_r ^ {lfsr_r[7:0], lfsr_r}};
  assign disp = $signed({3'h0, spic_ones(payload)} << 1) - spic_pkg::DISP_MID;
  assign invert = (rd_r > 8'sh0 && disp > 8'sh0) || (rd_r < 8'sh0 && disp < 8'sh0);

  always_ff @(posedge pixel_clock_in) begin
    if (!lrst_n_r) begin
      lfsr_r <= spic_pkg::LFSR_SEED;
      rd_r <= 8'sh0;
      sym_r <= spic_pkg::SYM_IDLE; // line held high while down
      sym_vld_r <= 1'b0;
    end else begin
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      rd_r <= invert ? rd_r - disp : rd_r + disp;
      sym_r <= {1'b1, invert, invert ? ~payload : payload, 1'b0};
      sym_vld_r <= 1'b1;
    end
  end

  assign tx_symbol = sym_r;
  assign tx_symbol_valid = sym_vld_r;

  // vsync rising edges counted and published as gray code
  always_ff @(posedge pixel_clock_in) begin
    if (!lrst_n_r) begin
      vs_prev_r <= 1'b0;
      vcnt_r <= 16'h0;
      vcnt_gray_r <= 16'h0;
    end else begin
      vs_prev_r <= ctl_tx_r[2];
      if (ctl_tx_r[2] && !vs_prev_r) begin
        vcnt_r <= vcnt_r + 16'h1;
      end
      vcnt_gray_r <= vcnt_r ^ (vcnt_r >> 1);
    end
  end

endmodule

`default_nettype wire

/* spic_top_bench.sv */
// bench for the pixel capture block: bus tasks, symbol decode, filter table
`timescale 1ns/1ps
`default_nettype none
module spic_top_bench;
  logic clk = 1'h0, rst_n = 1'h0, power_down_n = 1'h1, strobe_edge_select = 1'h1;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, r;
  logic [23:0] word = 24'h0, pixel_data_in;
  logic [1:0] s_axi_bresp, s_axi_rresp, m;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic pixel_clock_in, ctl_in_data_enable, ctl_in_hsync, ctl_in_vsync, tx_symbol_valid;
  logic [29:0] tx_symbol;
  logic [26:0] pl;
  logic [15:0] lfsr;
  logic [33:0] ax_q[$], px_q[$];
  spic_pkg::spic_ctl_t ctl = '0, ctl_p;
  int compares = 0, fail_count = 0, cyc = 0, hs_cnt = 0, rd = 0;

  spic_top uut (.*);
  spic_src src (.edge_sel(strobe_edge_select), .word(word), .ctl(ctl),
    .pclk(pixel_clock_in), .pix(pixel_data_in), .ctl_o(ctl_p));
  assign {ctl_in_vsync, ctl_in_hsync, ctl_in_data_enable} = ctl_p;

  always #20 clk = ~clk;

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task conclude;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // wait for n launch edges of the source
  task automatic pwait(input int n);
    repeat (n) begin
      if (strobe_edge_select) @(negedge pixel_clock_in);
      else @(posedge pixel_clock_in);
    end
  endtask

  // hsync pulse of n samples, then low again
  task automatic pulse(input int n);
    @(posedge clk);
    ctl.hsync <= 1'h1;
    pwait(n);
    @(posedge clk);
    ctl.hsync <= 1'h0;
  endtask

  // one bus write (w=1) or read, expected answer noted first
  task automatic xfer(input bit w, input logic [3:0] a, input logic [31:0] d,
    input logic [1:0] e);
    bit pa, pw;
    ax_q.push_back({e, w ? 32'h0 : d});
    pa = 1;
    pw = w;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_arvalid <= !w;
    s_axi_bready <= w;
    s_axi_rready <= !w;
    while (pa || pw) begin
      @(negedge clk);
      if (w ? s_axi_awready : s_axi_arready) pa = 0;
      if (s_axi_wready) pw = 0;
      @(posedge clk);
      s_axi_awvalid <= w && pa;
      s_axi_wvalid <= pw;
      s_axi_arvalid <= !w && pa;
    end
    do @(negedge clk); while (!(w ? s_axi_bvalid : s_axi_rvalid));
    @(posedge clk);
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
  endtask

  // bus answers against the oldest note, plus the hang limit
  always @(posedge clk) begin
    if (s_axi_bvalid && s_axi_bready)
      chk({s_axi_bresp, 32'h0}, ax_q.pop_front());
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata}, ax_q.pop_front());
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      conclude();
    end
  end

  // undo balance and scrambling on each symbol, compare with the oldest note
  always @(negedge pixel_clock_in) begin
    if (tx_symbol_valid !== 1'h1) begin
      lfsr = spic_pkg::LFSR_SEED;
      rd = 0;
    end else begin
      pl = tx_symbol[28] ? ~tx_symbol[27:1] : tx_symbol[27:1];
      hs_cnt += 32'(pl[25]);
      // balance counts the whole line symbol, framing and invert flag included
      rd += 2 * $countones(tx_symbol) - 30;
      if (rd > 99 || rd < -99) chk(34'h1, 34'h0);
      if (px_q.size() > 0)
        chk({7'h0, pl ^ {3'h0, lfsr[7:0], lfsr}}, px_q.pop_front());
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
  end

  initial begin
    void'($urandom(32));
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    xfer(1, 4'hc, 32'h5, spic_pkg::RESP_SLVERR);
    xfer(0, 4'hc, 32'h0, spic_pkg::RESP_SLVERR);
    for (int s = 1; s >= 0; s--) begin
      // power-down clears the mode and restarts the link on the new edge
      xfer(1, spic_pkg::REG_CTRL, 32'h1, spic_pkg::RESP_OKAY);
      // new pins while down, so the link restarts on settled values
      word <= 24'($urandom);
      ctl <= 3'($urandom) & 3'h5;
      power_down_n <= 1'h0;
      strobe_edge_select <= s[0];
      repeat (20) @(posedge clk);
      // while down: mode cleared, controls reset, power-down flag set
      xfer(0, spic_pkg::REG_STATUS, {28'h0, 1'h1, 3'h0}, spic_pkg::RESP_OKAY);
      power_down_n <= 1'h1;
      xfer(0, spic_pkg::REG_CTRL, 32'h0, spic_pkg::RESP_OKAY);
      pwait(140);
      repeat (4) px_q.push_back({7'h0, ctl, word});
      xfer(0, spic_pkg::REG_STATUS, {29'h0, ctl}, spic_pkg::RESP_OKAY);
      // count restarts at the link reset, so it holds one rise at most
      xfer(0, spic_pkg::REG_VSYNC_CNT, {31'h0, ctl.vsync}, spic_pkg::RESP_OKAY);
      // filter mode table: short and long hsync pulses
      for (int i = 0; i < 5; i++) begin
        m = i[1:0] | {1'h0, i == 4};
        r = $urandom;
        xfer(1, spic_pkg::REG_CTRL, {r[31:2], m}, spic_pkg::RESP_OKAY);
        xfer(0, spic_pkg::REG_CTRL, {30'h0, m}, spic_pkg::RESP_OKAY);
        pwait(140);
        xfer(0, spic_pkg::REG_STATUS, {26'h0, m, 1'h0, ctl}, spic_pkg::RESP_OKAY);
        hs_cnt = 0;
        pulse(i == 4 ? 3 : 2);
        pwait(140);
        chk(34'(hs_cnt), m != 2'h1 ? 34'h2 :
          i == 4 ? 34'h3 : 34'h0);
      end
    end
    conclude();
  end
endmodule

bind spic_top spic_chk u_chk (.clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pixel_clock_in, .power_down_n, .tx_symbol,
  .tx_symbol_valid);
`default_nettype wire

/* spic_top_chk.sv */
// assertions on the bus handshake, power-down and line symbols
`timescale 1ns/1ps
`default_nettype none
module spic_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pixel_clock_in,
  input wire logic power_down_n,
  input wire logic [29:0] tx_symbol,
  input wire logic tx_symbol_valid
);
  // both write channels taken at one edge
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // response waiting on the master
  sequence b_waits;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  a_write_answer: assert property (@(posedge clk) disable iff (!rst_n)
    wr_taken |=> s_axi_bvalid) else $error("write response late");
  a_read_answer: assert property (@(posedge clk) disable iff (!rst_n)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data late");
  a_bresp_hold: assert property (@(posedge clk) disable iff (!rst_n)
    b_waits |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (@(posedge clk) disable iff (!rst_n)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_refused: assert property (@(posedge clk) disable iff (!rst_n)
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  a_idle_line: assert property (@(negedge pixel_clock_in) disable iff (!rst_n)
    !tx_symbol_valid |-> tx_symbol == spic_pkg::SYM_IDLE) else $error("line not idle");
  a_symbol_frame: assert property (@(negedge pixel_clock_in) disable iff (!rst_n)
    tx_symbol_valid |-> tx_symbol[29] && !tx_symbol[0]) else $error("bad symbol frame");
  a_power_drop: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(power_down_n) |-> ##[1:20] !tx_symbol_valid) else $error("power-down ignored");
endmodule
`default_nettype wire
